// ===== rtl/stc_pkg.sv
package stc_pkg;

  // register indices; byte address is four times the index
  localparam logic [19:0] IDX_SAMPLE_RATE = 20'h04E20;
  localparam logic [19:0] IDX_COMMAND = 20'h0B798;
  localparam logic [19:0] IDX_SUPPORTED = 20'h0B799;
  localparam logic [19:0] IDX_RESET_TIME = 20'h0B7B6;
  localparam logic [19:0] IDX_RESET_DATE = 20'h0B7B7;
  localparam logic [19:0] IDX_TIMEOUT = 20'h0B7C5;
  localparam logic [19:0] IDX_STATUS = 20'h0B7F0;
  localparam logic [19:0] IDX_OVERSAMPLE = 20'h30DBB;

  // command codes
  localparam logic [31:0] STAMP_OFF_CODE = 32'h0000_0000;
  localparam logic [31:0] COUNTER_CLEAR_CMD = 32'h0000_0001;
  localparam logic [31:0] EXPLICIT_RESET_MODE = 32'h0000_0002;
  localparam logic [31:0] START_RESET_MODE = 32'h0000_0004;
  localparam logic [31:0] SAMPLE_CLOCK_SOURCE = 32'h0000_0100;
  localparam logic [31:0] REFCLK_RISING_SOURCE = 32'h0000_0200;
  localparam logic [31:0] REFCLK_FALLING_SOURCE = 32'h0000_0400;
  localparam logic [31:0] AUX_INPUT_CAPTURE_ON = 32'h0000_1000;
  localparam logic [31:0] AUX_INPUT_CAPTURE_OFF = 32'h0000_0000;
  localparam logic [31:0] NO_EXTRA_STAMP = 32'h0000_0000;
  localparam logic [31:0] FIRST_FAST_AREA_STAMP = 32'h0001_0000;

  // reset values
  localparam logic [31:0] COMMAND_RST = 32'h0000_0000;
  localparam logic [31:0] TIMEOUT_RST = 32'h0000_0000;
  localparam logic [31:0] SUPPORTED_DEF = 32'h0001_1707;

  // status bit positions
  localparam int ST_WAIT_BIT = 0;
  localparam int ST_TIMEOUT_BIT = 1;
  localparam int ST_LOST_BIT = 2;
  localparam int ST_CLKGEN_BIT = 3;

  // time base
  localparam int unsigned MS_IN_NS = 1000000;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned CYC_PER_MS_DEF = MS_IN_NS / CLK_PERIOD_NS;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {
    STC_IDLE = 1'b0,
    STC_WAIT_EDGE = 1'b1
  } stc_wait_t;

endpackage

// ===== rtl/stc_top.sv
// timestamp counter with command registers on an axi4-lite slave
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module stc_top #(
  parameter int unsigned CYC_PER_MS = stc_pkg::CYC_PER_MS_DEF,
  parameter int unsigned LOW_W = 32,
  parameter int unsigned AUX_W = 8,
  parameter logic [31:0] SUPPORTED = stc_pkg::SUPPORTED_DEF
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [19:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [19:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // acquisition side, same clock domain
  input wire logic sample_en,
  input wire logic clkgen_active,
  input wire logic card_start,
  input wire logic trigger_event,
  input wire logic gate_start,
  input wire logic gate_end,
  input wire logic fast_area_first,
  input wire logic [31:0] sample_rate,
  input wire logic [31:0] oversample_in,
  // host wall clock
  input wire logic [7:0] host_hours,
  input wire logic [7:0] host_minutes,
  input wire logic [7:0] host_seconds,
  input wire logic [15:0] host_year,
  input wire logic [7:0] host_month,
  input wire logic [7:0] host_day,
  // pins from the timing source
  input wire logic refclk_pin,
  input wire logic [AUX_W-1:0] aux_pin,
  // stamp output
  output logic stamp_valid,
  output logic [63:0] stamp_data,
  input wire logic stamp_ready
);
  import stc_pkg::*;

  typedef struct packed {
    logic [31:0] command;
    logic [31:0] timeout;
    logic [31:0] reset_time;
    logic [31:0] reset_date;
    logic [63:0] count;
    stc_wait_t wait_st;
    logic [31:0] ms_cyc;
    logic [31:0] ms_left;
    logic timeout_fail;
    logic stamp_lost;
    logic ref_s1;
    logic ref_s2;
    logic ref_s3;
    logic [AUX_W-1:0] aux_s1;
    logic [AUX_W-1:0] aux_s2;
    logic aw_got;
    logic [19:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic stamp_valid;
    logic [63:0] stamp_data;
  } stc_state_t;

  stc_state_t q;
  stc_state_t d;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = data[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [19:0] reg_index(input logic [19:0] addr);
    return {2'h0, addr[19:2]};
  endfunction

  localparam logic [31:0] CYC_PER_MS_W = 32'(CYC_PER_MS);
  localparam logic [63:0] LOW_ONE = 64'h1;
  localparam logic [63:0] LOW_MASK = (LOW_ONE << LOW_W) - 64'h1;

  logic split_mode;
  logic ref_edge;
  logic mode_on;
  logic stamp_event;
  logic wr_fire;
  logic clear_fire;
  logic wait_edge_done;
  logic [19:0] wr_idx;
  logic [19:0] rd_idx;
  logic [31:0] wr_val;
  logic [31:0] status_word;
  logic [31:0] rd_val;
  logic rd_hit;
  logic [63:0] stamp_val;
  logic [31:0] time_word;
  logic [31:0] date_word;

  always_comb begin
    d = q;

    // pin synchronisers; stage one feeds stage two only
    d.ref_s1 = refclk_pin;
    d.ref_s2 = q.ref_s1;
    d.ref_s3 = q.ref_s2;
    d.aux_s1 = aux_pin;
    d.aux_s2 = q.aux_s1;

    split_mode = (q.command[9] | q.command[10]);
    // the third stage only serves edge detection; it idles low like the pin after reset
    if (q.command[10]) begin
      ref_edge = q.ref_s3 & ~q.ref_s2;
    end else begin
      ref_edge = q.ref_s2 & ~q.ref_s3;
    end
    mode_on = (q.command[1] | q.command[2]);

    time_word = {8'h00, host_hours, host_minutes, host_seconds};
    date_word = {host_year, host_month, host_day};

    // write channel: address and data taken in either order
    if (s_axi_awvalid && q.awready) begin
      d.aw_got = 1'b1;
      d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      d.w_got = 1'b1;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end
    wr_fire = q.aw_got && q.w_got && !q.bvalid;
    wr_idx = reg_index(q.awaddr);
    clear_fire = 1'b0;
    wr_val = 32'h0000_0000;
    if (s_axi_bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (wr_fire) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = RESP_OKAY;
      unique case (wr_idx)
        IDX_COMMAND: begin
          wr_val = merge_bytes(q.command, q.wdata, q.wstrb);
          // the bare clear code is a command and keeps the programmed mode
          if (wr_val == COUNTER_CLEAR_CMD) begin
            clear_fire = 1'b1;
          end else begin
            d.command = wr_val;
          end
        end
        IDX_TIMEOUT: begin
          d.timeout = merge_bytes(q.timeout, q.wdata, q.wstrb);
        end
        IDX_RESET_TIME: begin
          d.reset_time = merge_bytes(q.reset_time, q.wdata, q.wstrb);
        end
        IDX_RESET_DATE: begin
          d.reset_date = merge_bytes(q.reset_date, q.wdata, q.wstrb);
        end
        IDX_SAMPLE_RATE, IDX_SUPPORTED, IDX_STATUS, IDX_OVERSAMPLE: begin
          d.bresp = RESP_OKAY;
        end
        default: begin
          d.bresp = RESP_SLVERR;
        end
      endcase
    end else begin
      wr_val = 32'h0000_0000;
    end
    // readys stay low while a response is pending, so only one write is ever in flight
    d.awready = !d.aw_got && !d.bvalid;
    d.wready = !d.w_got && !d.bvalid;

    // counting; disabled mode holds the count
    // sample_en is the base-rate pulse, so interlaced doubling never reaches the count
    if (mode_on && sample_en) begin
      if (split_mode) begin
        d.count = (q.count & ~LOW_MASK) | ((q.count + 64'h1) & LOW_MASK);
      end else begin
        d.count = q.count + 64'h1;
      end
    end
    if (mode_on && split_mode && ref_edge) begin
      d.count = (q.count & ~LOW_MASK) + (LOW_MASK + 64'h1);
    end
    if (q.command[2] && card_start) begin
      d.count = 64'h0;
    end

    // clear command; ignored while clock generation is idle
    wait_edge_done = 1'b0;
    if (clear_fire && clkgen_active) begin
      d.timeout_fail = 1'b0;
      if (split_mode) begin
        d.wait_st = STC_WAIT_EDGE;
        d.ms_cyc = 32'h0;
        d.ms_left = q.timeout;
      end else begin
        d.count = 64'h0;
        d.reset_time = time_word;
        d.reset_date = date_word;
      end
    end
    unique case (q.wait_st)
      STC_IDLE: begin
        wait_edge_done = 1'b0;
      end
      STC_WAIT_EDGE: begin
        if (ref_edge) begin
          wait_edge_done = 1'b1;
          d.wait_st = STC_IDLE;
          d.count = 64'h0;
          d.reset_time = time_word;
          d.reset_date = date_word;
        end else if (q.ms_left == 32'h0) begin
          d.wait_st = STC_IDLE;
          d.timeout_fail = 1'b1;
        end else if (q.ms_cyc == CYC_PER_MS_W - 32'h1) begin
          d.ms_cyc = 32'h0;
          d.ms_left = q.ms_left - 32'h1;
        end else begin
          d.ms_cyc = q.ms_cyc + 32'h1;
        end
      end
    endcase

    // stamp generation from the count before this cycle's update
    if (q.command[12]) begin
      stamp_val = {q.aux_s2, q.count[63-AUX_W:0]};
    end else begin
      stamp_val = q.count;
    end
    stamp_event = 1'b0;
    if (mode_on) begin
      stamp_event = trigger_event || gate_start || gate_end;
      if (q.command[16] && fast_area_first) begin
        stamp_event = 1'b1;
      end
    end
    if (stamp_valid && stamp_ready) begin
      d.stamp_valid = 1'b0;
    end
    if (stamp_event) begin
      if (q.stamp_valid && !stamp_ready) begin
        // no queue here: a stamp that finds the output busy is lost and flagged
        d.stamp_lost = 1'b1;
      end else begin
        d.stamp_valid = 1'b1;
        d.stamp_data = stamp_val;
      end
    end
    if (clear_fire && clkgen_active) begin
      d.stamp_lost = q.stamp_lost & ~q.stamp_valid ? 1'b0 : d.stamp_lost;
    end

    // read channel
    status_word = 32'h0;
    status_word[ST_WAIT_BIT] = (q.wait_st == STC_WAIT_EDGE);
    status_word[ST_TIMEOUT_BIT] = q.timeout_fail;
    status_word[ST_LOST_BIT] = q.stamp_lost;
    status_word[ST_CLKGEN_BIT] = clkgen_active;
    rd_idx = reg_index(s_axi_araddr);
    rd_hit = 1'b1;
    // the address is decoded in the accept cycle, so no read address register is kept
    unique case (rd_idx)
      IDX_SAMPLE_RATE: begin
        rd_val = sample_rate;
      end
      IDX_COMMAND: begin
        rd_val = q.command;
      end
      IDX_SUPPORTED: begin
        rd_val = SUPPORTED;
      end
      IDX_RESET_TIME: begin
        rd_val = q.reset_time;
      end
      IDX_RESET_DATE: begin
        rd_val = q.reset_date;
      end
      IDX_TIMEOUT: begin
        rd_val = q.timeout;
      end
      IDX_STATUS: begin
        rd_val = status_word;
      end
      IDX_OVERSAMPLE: begin
        rd_val = (oversample_in == 32'h0) ? 32'h1 : oversample_in;
      end
      default: begin
        rd_val = 32'h0;
        rd_hit = 1'b0;
      end
    endcase
    if (s_axi_rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rdata = rd_val;
      d.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    d.arready = !d.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.command <= COMMAND_RST;
      q.timeout <= TIMEOUT_RST;
      q.wait_st <= STC_IDLE;
      q.awready <= 1'b1;
      q.wready <= 1'b1;
      q.arready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign stamp_valid = q.stamp_valid;
  assign stamp_data = q.stamp_data;

endmodule

// ===== test/stc_refsrc.sv
// timing-source model: reference clock pin and auxiliary input pins
`timescale 1ns/1ps
module stc_refsrc (
  // clock
  input wire logic aclk,
  // auxiliary level to present
  input wire logic [7:0] aux_val,
  // pins toward the block
  output logic refclk_pin,
  output logic [7:0] aux_pin
);
  // refclk only moves when a test commands an edge, so no stray edge can clear the counter
  initial refclk_pin = 1'b0;
  assign aux_pin = aux_val;
  task automatic drive(input logic lv);
    @(posedge aclk);
    refclk_pin <= lv;
  endtask
endmodule

// ===== test/stc_top_chk.sv
// concurrent checks on the register bus and stamp ports of the stamp counter
`timescale 1ns/1ps
module stc_top_chk (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic [1:0] s_axi_rresp,
  input wire logic [31:0] s_axi_rdata,
  // stamp side
  input wire logic trigger_event,
  input wire logic gate_start,
  input wire logic gate_end,
  input wire logic fast_area_first,
  input wire logic stamp_valid,
  input wire logic stamp_ready,
  input wire logic [63:0] stamp_data
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic any_ev;
  assign any_ev = trigger_event | gate_start | gate_end | fast_area_first;
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_stamp_stall;
    stamp_valid && !stamp_ready;
  endsequence
  a_write_answer: assert property (s_wr_both |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("read answer late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data moved");
  a_stamp_cause: assert property ($rose(stamp_valid) |-> $past(any_ev))
    else $error("stamp without event");
  a_stamp_hold: assert property (s_stamp_stall |=>
    stamp_valid && $stable(stamp_data)) else $error("stalled stamp changed");
  a_stamp_free: assert property (stamp_valid && stamp_ready && !any_ev |=>
    !stamp_valid) else $error("accepted stamp not released");
endmodule
bind stc_top stc_top_chk u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_bresp(s_axi_bresp), .s_axi_rresp(s_axi_rresp),
  .s_axi_rdata(s_axi_rdata), .trigger_event(trigger_event), .gate_start(gate_start),
  .gate_end(gate_end), .fast_area_first(fast_area_first), .stamp_valid(stamp_valid),
  .stamp_ready(stamp_ready), .stamp_data(stamp_data));

// ===== test/testbench.sv
// self-checking bench for the stamp counter
`timescale 1ns/1ps
module testbench;
  import stc_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [19:0] s_axi_awaddr = 20'h0, s_axi_araddr = 20'h0;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, r;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, stamp_valid;
  logic [1:0] s_axi_bresp, s_axi_rresp, p;
  logic [63:0] stamp_data;
  logic sample_en = 1'b0, clkgen_active = 1'b0, card_start = 1'b0, stamp_ready = 1'b1;
  logic trigger_event = 1'b0, gate_start = 1'b0, gate_end = 1'b0, fast_area_first = 1'b0;
  logic [31:0] sample_rate = 32'h05F5E100, oversample_in = 32'h0;
  logic [7:0] host_hours = 8'h0D, host_minutes = 8'h2A, host_seconds = 8'h07;
  logic [7:0] host_month = 8'h06, host_day = 8'h1C, aux_pin, aux_val = 8'h0;
  logic [15:0] host_year = 16'h07E8;
  logic refclk_pin;
  int miscompares = 0, samples_checked = 0;
  always #50 aclk = ~aclk;
  // ten cycles per millisecond keeps the timeout case short
  stc_top #(.CYC_PER_MS(10)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(s_axi_arprot), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .sample_en(sample_en), .clkgen_active(clkgen_active),
    .card_start(card_start), .trigger_event(trigger_event), .gate_start(gate_start),
    .gate_end(gate_end), .fast_area_first(fast_area_first), .sample_rate(sample_rate),
    .oversample_in(oversample_in), .host_hours(host_hours), .host_minutes(host_minutes),
    .host_seconds(host_seconds), .host_year(host_year), .host_month(host_month),
    .host_day(host_day), .refclk_pin(refclk_pin), .aux_pin(aux_pin), .stamp_valid(stamp_valid),
    .stamp_data(stamp_data), .stamp_ready(stamp_ready));
  stc_refsrc src (.aclk(aclk), .aux_val(aux_val), .refclk_pin(refclk_pin), .aux_pin(aux_pin));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
    samples_checked++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [19:0] i, input logic [31:0] d);
    s_axi_awaddr <= {i[17:0], 2'b00};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    p = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [19:0] i);
    s_axi_araddr <= {i[17:0], 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    r = s_axi_rdata;
    p = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  // pulse events (bit0 trigger .. bit3 fast area) and look for one stamp
  task automatic stamp(input logic [3:0] m, input logic ev, input logic [63:0] e);
    logic v;
    logic [63:0] d;
    v = 1'b0;
    d = 64'h0;
    {fast_area_first, gate_end, gate_start, trigger_event} <= m;
    @(posedge aclk);
    {fast_area_first, gate_end, gate_start, trigger_event} <= 4'h0;
    repeat (3) begin
      @(posedge aclk);
      if (stamp_valid === 1'b1 && !v) begin
        v = 1'b1;
        d = stamp_data;
      end
    end
    chk("stamp_valid", {63'h0, v}, {63'h0, ev});
    if (ev) chk("stamp_data", d, e);
  endtask
  task automatic cnt(input int k);
    repeat (k) begin
      sample_en <= 1'b1;
      @(posedge aclk);
    end
    sample_en <= 1'b0;
    card_start <= 1'b1;
    @(posedge aclk);
    card_start <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic edge_wait(input logic lv);
    src.drive(lv);
    repeat (6) @(posedge aclk);
  endtask
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    wr(IDX_SUPPORTED, 32'h0);
    chk("ro write resp", p, RESP_OKAY);
    rd(IDX_SUPPORTED);
    chk("supported", r, SUPPORTED_DEF);
    rd(IDX_OVERSAMPLE);
    chk("oversample none", r, 32'h1);
    oversample_in <= 32'h4;
    rd(IDX_OVERSAMPLE);
    chk("oversample", r, 32'h4);
    rd(20'h00040);
    chk("unmapped", p, RESP_SLVERR);
    wr(20'h00040, 32'h1);
    chk("unmapped write", p, RESP_SLVERR);
    stamp(4'h1, 1'b0, 64'h0);
    clkgen_active <= 1'b1;
    wr(IDX_COMMAND, EXPLICIT_RESET_MODE | SAMPLE_CLOCK_SOURCE);
    rd(IDX_COMMAND);
    chk("command", r, 32'h102);
    cnt(3);
    wr(IDX_COMMAND, COUNTER_CLEAR_CMD);
    stamp(4'h1, 1'b1, 64'h0);
    rd(IDX_RESET_TIME);
    chk("reset time", r, 32'h000D2A07);
    rd(IDX_RESET_DATE);
    chk("reset date", r, 32'h07E8061C);
    cnt(5);
    stamp(4'h2, 1'b1, 64'h5);
    stamp(4'h4, 1'b1, 64'h5);
    clkgen_active <= 1'b0;
    wr(IDX_COMMAND, COUNTER_CLEAR_CMD);
    stamp(4'h1, 1'b1, 64'h5);
    clkgen_active <= 1'b1;
    wr(IDX_COMMAND, START_RESET_MODE | SAMPLE_CLOCK_SOURCE);
    cnt(0);
    stamp(4'h1, 1'b1, 64'h0);
    aux_val <= 8'hA5;
    wr(IDX_COMMAND, 32'h1102);
    cnt(3);
    stamp(4'h1, 1'b1, 64'hA500_0000_0000_0003);
    wr(IDX_COMMAND, 32'h102);
    stamp(4'h1, 1'b1, 64'h3);
    stamp(4'h8, 1'b0, 64'h0);
    wr(IDX_COMMAND, 32'h10102);
    stamp(4'h8, 1'b1, 64'h3);
    stamp_ready <= 1'b0;
    trigger_event <= 1'b1;
    @(posedge aclk);
    trigger_event <= 1'b0;
    repeat (4) @(posedge aclk);
    chk("stalled", stamp_valid, 1'b1);
    stamp_ready <= 1'b1;
    repeat (2) @(posedge aclk);
    chk("released", stamp_valid, 1'b0);
    wr(IDX_TIMEOUT, 32'h3E8);
    wr(IDX_COMMAND, EXPLICIT_RESET_MODE | REFCLK_RISING_SOURCE);
    wr(IDX_COMMAND, COUNTER_CLEAR_CMD);
    edge_wait(1'b1);
    stamp(4'h1, 1'b1, 64'h0);
    cnt(7);
    stamp(4'h1, 1'b1, 64'h7);
    edge_wait(1'b0);
    stamp(4'h1, 1'b1, 64'h7);
    edge_wait(1'b1);
    stamp(4'h1, 1'b1, 64'h1_0000_0000);
    wr(IDX_TIMEOUT, 32'h2);
    wr(IDX_COMMAND, COUNTER_CLEAR_CMD);
    rd(IDX_STATUS);
    chk("waiting", r[1:0], 2'b01);
    repeat (12) @(posedge aclk);
    rd(IDX_STATUS);
    chk("still waiting", r[1:0], 2'b01);
    repeat (30) @(posedge aclk);
    rd(IDX_STATUS);
    chk("timed out", r[1:0], 2'b10);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(IDX_TIMEOUT);
    chk("timeout after reset", r, TIMEOUT_RST);
    rd(IDX_COMMAND);
    chk("command after reset", r, COMMAND_RST);
    stamp(4'h1, 1'b0, 64'h0);
    give_verdict();
  end
  // a hang ends the run after far more cycles than the sequence needs
  initial begin
    repeat (5000) @(posedge aclk);
    miscompares++;
    give_verdict();
  end
endmodule
